// ---- common/rspd_map.svh ----
// Purpose: offsets, field positions, reset values and limits of the reference switchover and divider control block
// Assumes: register data is 8 bits wide, registers reached through a plain address/strobe port
// Notes: included by bare name
`ifndef RSPD_MAP_SVH
`define RSPD_MAP_SVH
// register offsets
`define RSPD_FB_A_OFS      10'h201
`define RSPD_FB_B_OFS      10'h204
`define RSPD_LF_OFS        10'h205
`define RSPD_FB_C_OFS      10'h207
`define RSPD_FB_D_OFS      10'h208
// reset values
`define RSPD_FB_A_RST      8'h0c
`define RSPD_FB_B_RST      8'h00
`define RSPD_LF_RST        8'h00
`define RSPD_FB_C_RST      8'h0a
`define RSPD_FB_D_RST      8'h00
// setting_a: calibration main counter b[5:0]
`define RSPD_B_LSB         0
// setting_b: remainder counter a[1:0], doubler bit 4, ref divider r[4:0] lives in setting_d
`define RSPD_A_LSB         0
`define RSPD_DBL_BIT       4
// setting_c: feedback counter n[7:0]
// setting_d: output divider m[1:0] (code 0..2 = /3../5), ref divider r at [7:3]
`define RSPD_M_LSB         0
`define RSPD_R_LSB         3
// limits
`define RSPD_REF_DIV_MAX   10'h3ff
`define RSPD_R_MAX         5'h1f
`define RSPD_B_MIN         6'h03
`define RSPD_CAL_MIN       9'h010
`define RSPD_M_MIN         3'h3
`define RSPD_M_MAX         3'h5
`endif

// ---- common/rspd_pkg.sv ----
// Purpose: types of the reference switchover and divider control block
// Assumes: nothing
// Notes: none
package rspd_pkg;
   typedef enum logic [1:0] {
      RSPD_ON_PRI  = 2'b00,
      RSPD_ON_SEC  = 2'b01,
      RSPD_HOLD    = 2'b10
   } rspd_state_e;
   typedef struct packed {
      logic       loop1_pd;
      logic       diff_sel;
      logic [1:0] se_pd;
      logic       auto_mode;
      logic       nonrevert;
      logic       man_sec;
      logic       use_pin;
      logic       hold_en;
      logic       hold_mid;
   } rspd_ctrl_s;
   typedef struct packed {
      logic       active_sec;
      logic       holdover;
      logic       cp_tristate;
      logic       vt_mid;
   } rspd_stat_s;
endpackage : rspd_pkg

// ---- rtl/rspd_ctrl.sv ----
// Purpose: reference receiver gating, reference dividers, switchover/holdover and second loop divider control
// Assumes: reference presence flags and reference clocks are synchronous to mclk
// Notes: divider outputs are single-cycle pulses at input-tick rate over ratio
//
// Functional notes
// - differential receiver off when not selected or first loop powered down.
// - single-ended buffer off when loop off, own power-down set, or differential chosen.
// - each reference has its own divider, ratio 1 to 1023.
// - manual selection from a register bit or the select pin.
// - automatic mode moves to secondary when primary lost and secondary present.
// - nonrevertive stays on secondary; returns to primary only if secondary lost.
// - revertive with no nonrevertive state latched goes back to primary as soon as primary returns.
// - nonrevertive state cleared by device reset or by the return to primary on secondary loss.
// - both references lost: holdover, tristate pump or drive tune voltage mid.
// - holdover ends when a reference returns; loop resyncs to it.
// - a control bit disables automatic holdover entry.
// - calibration selects the oscillator band automatically.
// - optional doubler on second loop reference; output within phase detector limit.
// - second loop reference divider ratio 1 to 31.
// - normal feedback is 8-bit counter times output divider.
// - calibration path only during calibration; reverts after; totals must match.
// - calibration divider is four times main plus remainder; main 3..63, total 16+.
// - output divider ratio three, four or five only; code 3 gives ratio six and sets cfg_error.
`timescale 1ns/10ps
`include "rspd_map.svh"
module rspd_ctrl #(
   parameter int REF_DIV_W = 10
) (
   input  wire logic                mclk,
   input  wire logic                resetn,
   input  wire logic [9:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   output logic      [7:0]          reg_rdata,
   input  wire rspd_pkg::rspd_ctrl_s ctrl,
   input  wire logic                ref_sel_pin,
   input  wire logic                pri_present,
   input  wire logic                sec_present,
   input  wire logic                pri_tick,
   input  wire logic                sec_tick,
   input  wire logic [REF_DIV_W-1:0] pri_ratio,
   input  wire logic [REF_DIV_W-1:0] sec_ratio,
   input  wire logic                cal_busy,
   output logic                     pri_div_out,
   output logic                     sec_div_out,
   output logic                     diff_rx_pd,
   output logic      [1:0]          se_buf_pd,
   output rspd_pkg::rspd_stat_s     status,
   output logic                     resync,
   output logic                     use_cal_path,
   output logic                     doubler_on,
   output logic      [4:0]          ref2_ratio,
   output logic      [8:0]          fb_total,
   output logic                     cfg_error
);
   if (REF_DIV_W != 10) begin : g_width_check
      $error("reference divider width must be 10");
   end
   // ***********************************
   // register file
   // ***********************************
   logic [7:0] fb_a, fb_b, lf, fb_c, fb_d;
   logic [7:0] next_fb_a, next_fb_b, next_lf, next_fb_c, next_fb_d, next_rdata;
   always_comb begin
      next_fb_a = fb_a;
      next_fb_b = fb_b;
      next_lf   = lf;
      next_fb_c = fb_c;
      next_fb_d = fb_d;
      if (reg_wr) begin
         unique case (reg_addr)
            `RSPD_FB_A_OFS: next_fb_a = reg_wdata;
            `RSPD_FB_B_OFS: next_fb_b = reg_wdata;
            `RSPD_LF_OFS:   next_lf   = reg_wdata;
            `RSPD_FB_C_OFS: next_fb_c = reg_wdata;
            `RSPD_FB_D_OFS: next_fb_d = reg_wdata;
            default: ;
         endcase
      end
      unique case (reg_addr)
         `RSPD_FB_A_OFS: next_rdata = fb_a;
         `RSPD_FB_B_OFS: next_rdata = fb_b;
         `RSPD_LF_OFS:   next_rdata = lf;
         `RSPD_FB_C_OFS: next_rdata = fb_c;
         `RSPD_FB_D_OFS: next_rdata = fb_d;
         default:        next_rdata = 8'h00;
      endcase
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         fb_a      <= `RSPD_FB_A_RST;
         fb_b      <= `RSPD_FB_B_RST;
         lf        <= `RSPD_LF_RST;
         fb_c      <= `RSPD_FB_C_RST;
         fb_d      <= `RSPD_FB_D_RST;
         reg_rdata <= 8'h00;
      end else begin
         fb_a      <= next_fb_a;
         fb_b      <= next_fb_b;
         lf        <= next_lf;
         fb_c      <= next_fb_c;
         fb_d      <= next_fb_d;
         reg_rdata <= next_rdata;
      end
   end
   // ***********************************
   // receiver gating
   // ***********************************
   logic       next_diff_pd;
   logic [1:0] next_se_pd;
   always_comb begin
      next_diff_pd = !ctrl.diff_sel || ctrl.loop1_pd;
      next_se_pd   = {2{ctrl.loop1_pd || ctrl.diff_sel}} | ctrl.se_pd;
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         diff_rx_pd <= 1'b1;
         se_buf_pd  <= 2'b11;
      end else begin
         diff_rx_pd <= next_diff_pd;
         se_buf_pd  <= next_se_pd;
      end
   end
   // ***********************************
   // reference dividers
   // ***********************************
   logic [1:0]                 tick_in;
   logic [1:0][REF_DIV_W-1:0]  ratio_in;
   logic [1:0][REF_DIV_W-1:0]  cnt, next_cnt;
   logic [1:0]                 dout, next_dout;
   assign tick_in  = {sec_tick, pri_tick};
   assign ratio_in = {sec_ratio, pri_ratio};
   for (genvar i = 0; i < 2; i++) begin : g_refdiv
      logic [REF_DIV_W-1:0] lim;
      // zero would already pulse on every tick through the compare; it is served as ratio one
      assign lim = (ratio_in[i] == '0) ? REF_DIV_W'(1) : ratio_in[i];
      always_comb begin
         next_cnt[i]  = cnt[i];
         next_dout[i] = 1'b0;
         if (tick_in[i]) begin
            if (cnt[i] + REF_DIV_W'(1) >= lim) begin
               next_cnt[i]  = '0;
               next_dout[i] = 1'b1;
            end else begin
               next_cnt[i] = cnt[i] + REF_DIV_W'(1);
            end
         end
      end
      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            cnt[i]  <= '0;
            dout[i] <= 1'b0;
         end else begin
            cnt[i]  <= next_cnt[i];
            dout[i] <= next_dout[i];
         end
      end
   end
   assign pri_div_out = dout[0];
   assign sec_div_out = dout[1];
   // ***********************************
   // switchover and holdover
   // ***********************************
   rspd_pkg::rspd_state_e state, next_state, last_ref, next_last_ref;
   logic                  nr_latched, next_nr_latched;
   logic                  man_sec;
   logic                  next_resync;
   assign man_sec = ctrl.use_pin ? ref_sel_pin : ctrl.man_sec;
   always_comb begin
      next_state      = state;
      next_last_ref   = last_ref;
      next_nr_latched = nr_latched;
      next_resync     = 1'b0;
      if (!ctrl.auto_mode) begin
         // manual: the system vouches for the chosen reference
         next_state = man_sec ? rspd_pkg::RSPD_ON_SEC : rspd_pkg::RSPD_ON_PRI;
      end else begin
         unique case (state)
            rspd_pkg::RSPD_ON_PRI: begin
               if (!pri_present && sec_present) begin
                  next_state = rspd_pkg::RSPD_ON_SEC;
                  if (ctrl.nonrevert) next_nr_latched = 1'b1;
               end else if (!pri_present && ctrl.hold_en) begin
                  next_state = rspd_pkg::RSPD_HOLD;
               end
            end
            rspd_pkg::RSPD_ON_SEC: begin
               if (!sec_present && pri_present) begin
                  next_state      = rspd_pkg::RSPD_ON_PRI;
                  next_nr_latched = 1'b0;
               end else if (!sec_present && ctrl.hold_en) begin
                  next_state = rspd_pkg::RSPD_HOLD;
               end else if (pri_present && !nr_latched && !ctrl.nonrevert) begin
                  next_state = rspd_pkg::RSPD_ON_PRI;
               end
            end
            rspd_pkg::RSPD_HOLD: begin
               // primary preferred unless locked to secondary by nonrevertive history
               if (pri_present && !(nr_latched && sec_present)) begin
                  next_state  = rspd_pkg::RSPD_ON_PRI;
                  next_resync = 1'b1;
               end else if (sec_present) begin
                  next_state  = rspd_pkg::RSPD_ON_SEC;
                  next_resync = 1'b1;
               end else if (!ctrl.hold_en) begin
                  next_state = last_ref;
               end
            end
            default: next_state = rspd_pkg::RSPD_ON_PRI;
         endcase
      end
      if (next_state != rspd_pkg::RSPD_HOLD) next_last_ref = next_state;
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state      <= rspd_pkg::RSPD_ON_PRI;
         last_ref   <= rspd_pkg::RSPD_ON_PRI;
         nr_latched <= 1'b0;
         resync     <= 1'b0;
         status     <= '0;
      end else begin
         state      <= next_state;
         last_ref   <= next_last_ref;
         nr_latched <= next_nr_latched;
         resync     <= next_resync;
         // status registered from next values so it changes with state
         status.active_sec  <= (next_state == rspd_pkg::RSPD_ON_SEC);
         status.holdover    <= (next_state == rspd_pkg::RSPD_HOLD);
         status.cp_tristate <= (next_state == rspd_pkg::RSPD_HOLD) && !ctrl.hold_mid;
         status.vt_mid      <= (next_state == rspd_pkg::RSPD_HOLD) && ctrl.hold_mid;
      end
   end
   // ***********************************
   // second loop dividers
   // ***********************************
   logic [5:0] cal_b;
   logic [1:0] cal_a;
   logic [2:0] m_ratio;
   logic [8:0] cal_total, norm_total;
   logic [10:0] norm_wide;
   logic [4:0] r_val;
   logic       next_err;
   logic [8:0] next_total;
   assign cal_b     = fb_a[`RSPD_B_LSB +: 6];
   assign cal_a     = fb_b[`RSPD_A_LSB +: 2];
   assign m_ratio   = `RSPD_M_MIN + {1'b0, fb_d[`RSPD_M_LSB +: 2]};
   assign cal_total = {1'b0, cal_b, 2'b00} + {7'h00, cal_a};
   assign norm_wide = fb_c * m_ratio;
   assign norm_total = norm_wide[8:0];
   assign r_val     = fb_d[`RSPD_R_LSB +: 5];
   always_comb begin
      next_err = (cal_b < `RSPD_B_MIN) || (cal_total < `RSPD_CAL_MIN)
               || (m_ratio > `RSPD_M_MAX) || (r_val == 5'h00)
               || (norm_wide != {2'b00, cal_total});
      // calibration path only while the band search runs
      next_total = cal_busy ? cal_total : norm_total;
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         use_cal_path <= 1'b0;
         doubler_on   <= 1'b0;
         ref2_ratio   <= 5'h01;
         fb_total     <= 9'h000;
         cfg_error    <= 1'b0;
      end else begin
         use_cal_path <= cal_busy;
         doubler_on   <= fb_b[`RSPD_DBL_BIT];
         ref2_ratio   <= (r_val == 5'h00) ? 5'h01 : r_val;
         fb_total     <= next_total;
         cfg_error    <= next_err;
      end
   end
   // ***********************************
   // checks
   // ***********************************
   sequence pri_lost_s;
      ctrl.auto_mode && state == rspd_pkg::RSPD_ON_PRI && !pri_present && sec_present;
   endsequence
   auto_switch_a: assert property (@(posedge mclk) disable iff (!resetn)
      pri_lost_s |=> state == rspd_pkg::RSPD_ON_SEC)
      else $error("no move to secondary on primary loss");
   status_track_a: assert property (@(posedge mclk) disable iff (!resetn)
      status.active_sec == (state == rspd_pkg::RSPD_ON_SEC))
      else $error("active reference status out of step");
   hold_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
      status.holdover == (state == rspd_pkg::RSPD_HOLD))
      else $error("holdover status out of step");
   nonrevert_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
      ctrl.auto_mode && nr_latched && state == rspd_pkg::RSPD_ON_SEC && sec_present
      |=> state == rspd_pkg::RSPD_ON_SEC)
      else $error("left secondary in nonrevertive mode");
   revert_a: assert property (@(posedge mclk) disable iff (!resetn)
      ctrl.auto_mode && !ctrl.nonrevert && !nr_latched && state == rspd_pkg::RSPD_ON_SEC
      && pri_present |=> state == rspd_pkg::RSPD_ON_PRI)
      else $error("no return to primary");
   hold_entry_a: assert property (@(posedge mclk) disable iff (!resetn)
      ctrl.auto_mode && !ctrl.hold_en |=> state != rspd_pkg::RSPD_HOLD || $past(state) == rspd_pkg::RSPD_HOLD)
      else $error("holdover entered while disabled");
   hold_exit_a: assert property (@(posedge mclk) disable iff (!resetn)
      ctrl.auto_mode && state == rspd_pkg::RSPD_HOLD && (pri_present || sec_present)
      |=> state != rspd_pkg::RSPD_HOLD ##0 resync)
      else $error("holdover not left");
   nr_sticky_a: assert property (@(posedge mclk) disable iff (!resetn)
      nr_latched && !(state == rspd_pkg::RSPD_ON_SEC && !sec_present && pri_present) |=> nr_latched)
      else $error("nonrevertive state lost");
   rx_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
      ctrl.loop1_pd |=> diff_rx_pd && se_buf_pd == 2'b11)
      else $error("receivers not gated");
   cal_path_a: assert property (@(posedge mclk) disable iff (!resetn)
      $fell(cal_busy) |=> !use_cal_path && fb_total == $past(norm_total))
      else $error("calibration path not released");
endmodule : rspd_ctrl

// ---- verification/rspd_ref_model.sv ----
// Purpose: model of the two reference clocks at the far side of rspd_ctrl
// Assumes: ticks and presence change off the falling edge of mclk
// Notes: a lost reference makes no ticks at all
`timescale 1ns/10ps
module rspd_ref_model #(
   parameter int PRI_PER = 3,
   parameter int SEC_PER = 2
) (
   input  wire logic mclk,
   input  wire logic pri_on,
   input  wire logic sec_on,
   output logic      pri_present,
   output logic      sec_present,
   output logic      pri_tick = 1'b0,
   output logic      sec_tick = 1'b0
);
   // ****************************************
   // reference sources
   // ****************************************
   int pc = 0;
   int sc = 0;
   assign pri_present = pri_on;
   assign sec_present = sec_on;
   always @(negedge mclk) begin
      pc = (pc + 1) % PRI_PER;
      sc = (sc + 1) % SEC_PER;
      pri_tick <= pri_on && pc == 0;
      sec_tick <= sec_on && sc == 0;
   end
endmodule : rspd_ref_model

// ---- verification/rspd_ctrl_test.sv ----
// Purpose: self-checking bench of rspd_ctrl
// Assumes: inputs change on the falling edge of mclk
// Notes: ratios fixed at 1 and 1023 so edge counts stay exact
`timescale 1ns/10ps
`include "rspd_map.svh"
module rspd_ctrl_test;
   // ****************************************
   // signals and instances
   // ****************************************
   logic                 mclk = 1'b0;
   logic                 resetn = 1'b0;
   logic [9:0]           reg_addr = 10'h000;
   logic [7:0]           reg_wdata = 8'h00;
   logic                 reg_wr = 1'b0;
   logic [7:0]           reg_rdata;
   rspd_pkg::rspd_ctrl_s ctrl = '0;
   rspd_pkg::rspd_stat_s status;
   logic                 ref_sel_pin = 1'b0;
   logic                 pri_on = 1'b1;
   logic                 sec_on = 1'b1;
   logic                 cal_busy = 1'b0;
   logic                 pri_present, sec_present, pri_tick, sec_tick;
   logic                 pri_div_out, sec_div_out, diff_rx_pd, resync;
   logic                 use_cal_path, doubler_on, cfg_error;
   logic [1:0]           se_buf_pd;
   logic [4:0]           ref2_ratio;
   logic [8:0]           fb_total;
   // loop-bandwidth period in mclk cycles, a plain stand-in value
   localparam int        LBW_PERIOD = 4;
   int                   rs = 0;
   int                   rs_base = 0;
   int                   num_errors = 0;
   int                   checked = 0;
   int                   cycles = 0;
   int                   pt, pt1, po, st, st1, so;

   rspd_ref_model rspd_ref_model_i (.mclk(mclk), .pri_on(pri_on), .sec_on(sec_on), .pri_present(pri_present),
      .sec_present(sec_present), .pri_tick(pri_tick), .sec_tick(sec_tick));

   rspd_ctrl rspd_ctrl_i (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rdata(reg_rdata), .ctrl(ctrl), .ref_sel_pin(ref_sel_pin),
      .pri_present(pri_present), .sec_present(sec_present), .pri_tick(pri_tick), .sec_tick(sec_tick),
      .pri_ratio(10'h001), .sec_ratio(10'h3ff), .cal_busy(cal_busy), .pri_div_out(pri_div_out),
      .sec_div_out(sec_div_out), .diff_rx_pd(diff_rx_pd), .se_buf_pd(se_buf_pd), .status(status),
      .resync(resync), .use_cal_path(use_cal_path), .doubler_on(doubler_on), .ref2_ratio(ref2_ratio),
      .fb_total(fb_total), .cfg_error(cfg_error));

   // ****************************************
   // tasks
   // ****************************************
   task automatic wrap_up();
      $display("TB: %0d checks, %0d errors", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(negedge mclk);
   endtask : step

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      @(negedge mclk);
      reg_addr = a;
      @(negedge mclk);
      chk({8'h00, reg_rdata}, {8'h00, e}, "read");
   endtask : rd

   // presence is applied on a falling edge and the status looked at two edges later
   task automatic refs(input logic p, input logic s, input logic es, input logic eh);
      pri_on = p;
      sec_on = s;
      step(2);
      chk({15'h0, status.active_sec}, {15'h0, es}, "active sec");
      chk({15'h0, status.holdover}, {15'h0, eh}, "holdover");
   endtask : refs

   task automatic cfg(input logic [7:0] b, a, n, d, input logic [8:0] tot, input logic err);
      wr(`RSPD_FB_A_OFS, b);
      wr(`RSPD_FB_B_OFS, a);
      wr(`RSPD_FB_C_OFS, n);
      wr(`RSPD_FB_D_OFS, d);
      step(2);
      if (tot != 9'h1ff) chk({7'h0, fb_total}, {7'h0, tot}, "fb total");
      chk({15'h0, cfg_error}, {15'h0, err}, "cfg error");
   endtask : cfg

   // ****************************************
   // clock, monitors and tests
   // ****************************************
   initial begin
      forever #20 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      rs <= resetn ? rs + resync : 0;
      pt1 <= resetn ? pt : 0;
      st1 <= resetn ? st : 0;
      pt <= resetn ? pt + pri_tick : 0;
      st <= resetn ? st + sec_tick : 0;
      po <= resetn ? po + pri_div_out : 0;
      so <= resetn ? so + sec_div_out : 0;
      if (cycles == 6000) begin
         num_errors = num_errors + 1;
         wrap_up();
      end
   end

   initial begin
      step(8);
      resetn = 1'b1;
      rd(`RSPD_FB_A_OFS, `RSPD_FB_A_RST);
      rd(`RSPD_FB_B_OFS, `RSPD_FB_B_RST);
      rd(`RSPD_LF_OFS, `RSPD_LF_RST);
      rd(`RSPD_FB_C_OFS, `RSPD_FB_C_RST);
      rd(`RSPD_FB_D_OFS, `RSPD_FB_D_RST);
      wr(`RSPD_LF_OFS, 8'h5a);
      wr(10'h206, 8'h77);
      rd(`RSPD_LF_OFS, 8'h5a);
      rd(10'h206, 8'h00);
      $display("TB: registers done");
      for (int i = 0; i < 16; i++) begin
         ctrl = '{loop1_pd: i[0], diff_sel: i[1], se_pd: i[3:2], default: '0};
         step(2);
         chk({15'h0, diff_rx_pd}, {15'h0, i[0] | ~i[1]}, "diff rx");
         chk({14'h0, se_buf_pd}, {14'h0, {2{i[0] | i[1]}} | i[3:2]}, "se buf");
      end
      $display("TB: gating done");
      // secondary is already present before the manual move
      ctrl = '{man_sec: 1'b1, default: '0};
      refs(1'b1, 1'b1, 1'b1, 1'b0);
      ctrl.use_pin = 1'b1;
      refs(1'b1, 1'b1, 1'b0, 1'b0);
      ref_sel_pin = 1'b1;
      refs(1'b1, 1'b1, 1'b1, 1'b0);
      ctrl = '{auto_mode: 1'b1, default: '0};
      refs(1'b1, 1'b1, 1'b0, 1'b0);
      refs(1'b0, 1'b1, 1'b1, 1'b0);
      refs(1'b1, 1'b1, 1'b0, 1'b0);
      ctrl.nonrevert = 1'b1;
      refs(1'b0, 1'b1, 1'b1, 1'b0);
      refs(1'b1, 1'b1, 1'b1, 1'b0);
      ctrl.nonrevert = 1'b0;
      step(2);
      ctrl.nonrevert = 1'b1;
      refs(1'b1, 1'b1, 1'b1, 1'b0);
      resetn = 1'b0;
      step(2);
      resetn = 1'b1;
      refs(1'b1, 1'b1, 1'b0, 1'b0);
      refs(1'b0, 1'b1, 1'b1, 1'b0);
      refs(1'b1, 1'b0, 1'b0, 1'b0);
      $display("TB: switchover done");
      ctrl.hold_en = 1'b1;
      refs(1'b0, 1'b0, 1'b0, 1'b1);
      chk({15'h0, status.cp_tristate}, 16'h0001, "pump off");
      chk({15'h0, status.vt_mid}, 16'h0000, "tune mid");
      rs_base = rs;
      refs(1'b1, 1'b1, 1'b0, 1'b0);
      chk(16'(rs - rs_base), 16'h0001, "resync");
      // software gives the first loop its lock timeout before relying on lock
      step(10 * LBW_PERIOD);
      ctrl.hold_mid = 1'b1;
      refs(1'b0, 1'b0, 1'b0, 1'b1);
      chk({15'h0, status.vt_mid}, 16'h0001, "tune mid");
      chk({15'h0, status.cp_tristate}, 16'h0000, "pump off");
      rs_base = rs;
      refs(1'b0, 1'b1, 1'b1, 1'b0);
      chk(16'(rs - rs_base), 16'h0001, "resync");
      refs(1'b1, 1'b0, 1'b0, 1'b0);
      ctrl.hold_en = 1'b0;
      refs(1'b0, 1'b0, 1'b0, 1'b0);
      refs(1'b1, 1'b1, 1'b0, 1'b0);
      $display("TB: holdover done");
      cfg(8'h07, 8'h12, 8'h0a, 8'h08, 9'd30, 1'b0);
      // with the doubler running, software feeds the sync pulse generator from the feedback path
      chk({15'h0, doubler_on}, 16'h0001, "doubler");
      chk({11'h0, ref2_ratio}, 16'h0001, "ref2 ratio");
      cfg(8'h07, 8'h02, 8'h0a, 8'h0a, 9'd50, 1'b1);
      cal_busy = 1'b1;
      step(2);
      chk({7'h0, fb_total}, 16'd30, "cal total");
      chk({15'h0, use_cal_path}, 16'h0001, "cal path");
      cal_busy = 1'b0;
      step(2);
      chk({7'h0, fb_total}, 16'd50, "normal total");
      chk({15'h0, use_cal_path}, 16'h0000, "cal path");
      cfg(8'h03, 8'h00, 8'h04, 8'h08, 9'd12, 1'b1);
      cfg(8'h08, 8'h00, 8'h08, 8'hf9, 9'd32, 1'b0);
      chk({11'h0, ref2_ratio}, 16'h001f, "ref2 ratio");
      chk({15'h0, doubler_on}, 16'h0000, "doubler");
      cfg(8'h08, 8'h00, 8'h08, 8'h01, 9'd32, 1'b1);
      chk({11'h0, ref2_ratio}, 16'h0001, "ref2 ratio");
      cfg(8'h08, 8'h00, 8'h08, 8'h0b, 9'h1ff, 1'b1);
      $display("TB: second loop done");
      step(2100);
      chk(16'(po), 16'(pt1), "pri divider");
      chk(16'(so), 16'(st1 / 1023), "sec divider");
      chk(16'(so > 0), 16'h0001, "sec pulses");
      $display("TB: dividers done");
      wrap_up();
   end
endmodule : rspd_ctrl_test
